// *** hw/dmds_pkg.sv ***
// Constants for the two-channel monitor output selector and scaler.
// Assumes one clock domain and a plain register port with one-word registers.
`default_nettype none

package dmds_pkg;
  // ----------------------------------------------------------------------
  // Register map, byte addresses of 32-bit words
  // ----------------------------------------------------------------------
  localparam logic [7:0] DMDS_ADDR_SPEED_FS  = 8'h00;
  localparam logic [7:0] DMDS_ADDR_LOAD_V    = 8'h04;
  localparam logic [7:0] DMDS_ADDR_CH1_SEL   = 8'h08;
  localparam logic [7:0] DMDS_ADDR_CH2_SEL   = 8'h0C;
  localparam logic [7:0] DMDS_ADDR_CH1_GAIN  = 8'h10;
  localparam logic [7:0] DMDS_ADDR_CH2_GAIN  = 8'h14;
  localparam logic [7:0] DMDS_ADDR_SFW2      = 8'h18;
  localparam logic [7:0] DMDS_ADDR_STATUS    = 8'h1C;

  // Reset values
  localparam logic [15:0] DMDS_RST_PARAM     = 16'h0000;

  // Field positions
  localparam int DMDS_SFW2_SPECIAL_BIT       = 0;
  localparam int DMDS_SFW2_CHANGEOVER_BIT    = 2;
  localparam int DMDS_ST_CODE2_LSB           = 8;
  localparam int DMDS_ST_HIGH_BIT            = 16;
  localparam int DMDS_ST_LOW_BIT             = 17;
  localparam int DMDS_ST_SINGLE_BIT          = 18;

  // Data numbers
  localparam logic [15:0] DMDS_SEL_METER     = 16'h0000;
  localparam logic [15:0] DMDS_SEL_CUR_CMD   = 16'h0002;
  localparam logic [15:0] DMDS_SEL_CUR_FB    = 16'h0003;
  localparam logic [15:0] DMDS_SEL_SPEED_FB  = 16'h0004;
  localparam logic [15:0] DMDS_SEL_DROOP_LO  = 16'h0006;
  localparam logic [15:0] DMDS_SEL_DROOP_HI  = 16'h0007;
  localparam logic [15:0] DMDS_SEL_INCR_LO   = 16'h0008;
  localparam logic [15:0] DMDS_SEL_INCR_HI   = 16'h0009;
  localparam logic [15:0] DMDS_SEL_PCMD_LO   = 16'h000A;
  localparam logic [15:0] DMDS_SEL_PCMD_HI   = 16'h000B;
  localparam logic [15:0] DMDS_SEL_FBPOS_LO  = 16'h000C;
  localparam logic [15:0] DMDS_SEL_FBPOS_HI  = 16'h000D;
  localparam logic [15:0] DMDS_SEL_CTL_IN1   = 16'h0050;
  localparam logic [15:0] DMDS_SEL_CTL_OUT1  = 16'h0054;
  localparam logic [15:0] DMDS_SEL_CTL_SPAN  = 16'h0004;

  // Scaling figures
  localparam logic [16:0] DMDS_GAIN_UNITY    = 17'h00100;
  localparam int          DMDS_GAIN_SHIFT    = 8;
  localparam logic [7:0]  DMDS_CODE_MID      = 8'h80;
  localparam logic [7:0]  DMDS_CODE_FULL     = 8'hFF;
  localparam logic [7:0]  DMDS_CODE_ZERO     = 8'h00;
  localparam logic [3:0]  DMDS_LOAD_V_FULL   = 4'hA;
  // Load at 120 percent with 4096 per 100 percent, times 10 V
  localparam logic [31:0] DMDS_LOAD_DEN      = 32'h0000_BFFE;
  localparam logic [31:0] DMDS_METER_SPAN    = 32'h0000_00FF;
  localparam logic [2:0]  DMDS_DIV_TOP_BIT   = 3'h7;

  typedef enum logic [1:0] {DMDS_ST_START, DMDS_ST_DIV} dmds_state_type;
endpackage : dmds_pkg

`default_nettype wire

// *** hw/dmds_top.sv ***
// Two-channel monitor output selector and scaler feeding an 8-bit converter.
// Assumes internal quantities arrive synchronous to clk; registers via plain port.
//
// Local design decisions: the strobed register port and the address map.
`default_nettype none

// Operation
// - speed meter full scale at set speed
// - zero setting uses maximum motor speed
// - load meter volts at 120 percent, default 10
// - channel 1 select zero gives speed meter
// - channel 2 select zero gives load meter
// - scale data by gain over 256
// - gain zero acts as 256
// - numbers 2,3,4 current and speed data
// - current 100 percent is thirty-minute rating
// - numbers 6,7 position droop halves
// - numbers 10,11 command, 8,9 increment
// - numbers 12,13 feedback position halves
// - signed curve except meters unipolar
// - high-coil set when special bit 0
// - low-coil set when bits 0 and 2
module dmds_top (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire logic [15:0]         maximum_motor_speed,
  input  wire logic [15:0]         current_command,
  input  wire logic [15:0]         current_feedback,
  input  wire logic [15:0]         speed_feedback,
  input  wire logic [15:0]         motor_load,
  input  wire logic [31:0]         position_droop,
  input  wire logic [31:0]         position_increment,
  input  wire logic [31:0]         position_command,
  input  wire logic [31:0]         feedback_position,
  input  wire logic [3:0][15:0]    control_input_words,
  input  wire logic [3:0][15:0]    control_output_words,
  output logic      [7:0]          dac_code_ch1,
  output logic      [7:0]          dac_code_ch2,
  output logic                     high_coil_active,
  output logic                     low_coil_active,
  output logic                     single_coil_special
);
  import dmds_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------------
  logic [15:0]      speed_fs_r;
  logic [15:0]      load_v_r;
  logic [1:0][15:0] sel_r;
  logic [1:0][15:0] gain_r;
  logic [15:0]      sfw2_r;
  logic [31:0]      rdata_r;

  wire wr_speed = reg_wr && (reg_addr == DMDS_ADDR_SPEED_FS);
  wire wr_load  = reg_wr && (reg_addr == DMDS_ADDR_LOAD_V);
  wire wr_sel1  = reg_wr && (reg_addr == DMDS_ADDR_CH1_SEL);
  wire wr_sel2  = reg_wr && (reg_addr == DMDS_ADDR_CH2_SEL);
  wire wr_gain1 = reg_wr && (reg_addr == DMDS_ADDR_CH1_GAIN);
  wire wr_gain2 = reg_wr && (reg_addr == DMDS_ADDR_CH2_GAIN);
  wire wr_sfw2  = reg_wr && (reg_addr == DMDS_ADDR_SFW2);

  // Writes land whole; the meter logic tolerates out-of-range settings
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_fs_r <= DMDS_RST_PARAM;
      load_v_r   <= DMDS_RST_PARAM;
      sel_r      <= {2{DMDS_RST_PARAM}};
      gain_r     <= {2{DMDS_RST_PARAM}};
      sfw2_r     <= DMDS_RST_PARAM;
    end else begin
      if (wr_speed) speed_fs_r <= reg_wdata[15:0];
      if (wr_load)  load_v_r   <= reg_wdata[15:0];
      if (wr_sel1)  sel_r[0]   <= reg_wdata[15:0];
      if (wr_sel2)  sel_r[1]   <= reg_wdata[15:0];
      if (wr_gain1) gain_r[0]  <= reg_wdata[15:0];
      if (wr_gain2) gain_r[1]  <= reg_wdata[15:0];
      if (wr_sfw2)  sfw2_r     <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Coil parameter set selection
  // ----------------------------------------------------------------------
  // high set on special bit
  assign high_coil_active    = sfw2_r[DMDS_SFW2_SPECIAL_BIT];
  assign single_coil_special = sfw2_r[DMDS_SFW2_SPECIAL_BIT] &&
                               !sfw2_r[DMDS_SFW2_CHANGEOVER_BIT];
  assign low_coil_active     = sfw2_r[DMDS_SFW2_SPECIAL_BIT] &&
                               sfw2_r[DMDS_SFW2_CHANGEOVER_BIT];

  // ----------------------------------------------------------------------
  // Meter references
  // ----------------------------------------------------------------------
  // speed full scale from setting, top bit unused
  wire [15:0] fs_set   = {1'b0, speed_fs_r[14:0]};
  // zero falls back to maximum speed
  wire [15:0] eff_fs   = (fs_set == 16'h0000) ? maximum_motor_speed : fs_set;
  // zero or above range means 10 V
  wire        lv_def   = (load_v_r == 16'h0000) || (load_v_r > {12'h000, DMDS_LOAD_V_FULL});
  wire [3:0]  eff_lv   = lv_def ? DMDS_LOAD_V_FULL : load_v_r[3:0];
  // Speed meter is unipolar: magnitude of speed
  wire [15:0] abs_spd  = speed_feedback[15] ? 16'(-speed_feedback) : speed_feedback;
  wire [31:0] spd_num  = 32'(abs_spd) * DMDS_METER_SPAN;
  wire [31:0] load_num = 32'(motor_load) * 32'(eff_lv) * DMDS_METER_SPAN;

  // ----------------------------------------------------------------------
  // Shared meter divider, 8 quotient bits by restoring steps
  // ----------------------------------------------------------------------
  // One divider serves both meters in turn; each refresh takes about ten
  // cycles, far quicker than any meter needle or scope can follow.
  dmds_state_type st_r;
  logic        meter_r;               // 0 speed, 1 load
  logic [31:0] rem_r;
  logic [31:0] den_r;
  logic [31:0] num_lat_r;
  logic [2:0]  bit_r;
  logic [7:0]  quo_r;
  logic [7:0]  spd_code_r;
  logic [7:0]  load_code_r;

  wire [31:0] start_num = meter_r ? load_num : spd_num;
  wire [31:0] start_den = meter_r ? DMDS_LOAD_DEN : 32'(eff_fs);
  wire        start_sat = (start_den == 32'h0) || (start_num >= (start_den << DMDS_GAIN_SHIFT));
  wire [31:0] trial     = den_r << bit_r;
  wire        take      = rem_r >= trial;
  wire [7:0]  quo_step  = quo_r | (take ? (8'h01 << bit_r) : 8'h00);
  wire        div_last  = (st_r == DMDS_ST_DIV) && (bit_r == 3'h0);
  wire        sat_done  = (st_r == DMDS_ST_START) && start_sat;
  wire [7:0]  meter_res = sat_done ? DMDS_CODE_FULL : quo_step;
  wire        meter_upd = sat_done || div_last;

  // Divider sequencing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r      <= DMDS_ST_START;
      meter_r   <= 1'b0;
      rem_r     <= 32'h0;
      den_r     <= 32'h0;
      num_lat_r <= 32'h0;
      bit_r     <= DMDS_DIV_TOP_BIT;
      quo_r     <= DMDS_CODE_ZERO;
    end else begin
      unique case (st_r)
        DMDS_ST_START: begin
          rem_r     <= start_num;
          den_r     <= start_den;
          num_lat_r <= start_num;
          bit_r     <= DMDS_DIV_TOP_BIT;
          quo_r     <= DMDS_CODE_ZERO;
          if (start_sat) meter_r <= !meter_r;
          else st_r <= DMDS_ST_DIV;
        end
        DMDS_ST_DIV: begin
          if (take) rem_r <= rem_r - trial;
          quo_r <= quo_step;
          bit_r <= bit_r - 3'h1;
          if (bit_r == 3'h0) begin
            st_r    <= DMDS_ST_START;
            meter_r <= !meter_r;
          end
        end
      endcase
    end
  end

  // meters keep their own unipolar result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spd_code_r  <= DMDS_CODE_ZERO;
      load_code_r <= DMDS_CODE_ZERO;
    end else begin
      if (meter_upd && !meter_r) spd_code_r  <= meter_res;
      if (meter_upd && meter_r)  load_code_r <= meter_res;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel data selection and signed scaling
  // ----------------------------------------------------------------------
  logic [1:0][7:0]  code_r;
  logic [1:0][16:0] data_w;
  logic [1:0][16:0] gain_w;
  logic [1:0][33:0] scaled_w;
  logic [1:0][7:0]  lin_w;
  logic [1:0][7:0]  code_nxt;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      wire [15:0] s       = sel_r[c];
      wire [15:0] in_idx  = s - DMDS_SEL_CTL_IN1;
      wire [15:0] out_idx = s - DMDS_SEL_CTL_OUT1;
      wire        is_in   = (s >= DMDS_SEL_CTL_IN1) && (in_idx < DMDS_SEL_CTL_SPAN);
      wire        is_out  = (s >= DMDS_SEL_CTL_OUT1) && (out_idx < DMDS_SEL_CTL_SPAN);
      // current and speed, current in 4096 per rated 100 percent
      // droop halves, command and increment, feedback halves
      // control words zero-extended so each bit keeps its weight
      // Unknown numbers show zero data, that is mid-scale.
      assign data_w[c] =
        (s == DMDS_SEL_CUR_CMD)  ? 17'(signed'(current_command))           :
        (s == DMDS_SEL_CUR_FB)   ? 17'(signed'(current_feedback))          :
        (s == DMDS_SEL_SPEED_FB) ? 17'(signed'(speed_feedback))            :
        (s == DMDS_SEL_DROOP_LO) ? 17'(signed'(position_droop[15:0]))      :
        (s == DMDS_SEL_DROOP_HI) ? 17'(signed'(position_droop[31:16]))     :
        (s == DMDS_SEL_INCR_LO)  ? 17'(signed'(position_increment[15:0]))  :
        (s == DMDS_SEL_INCR_HI)  ? 17'(signed'(position_increment[31:16])) :
        (s == DMDS_SEL_PCMD_LO)  ? 17'(signed'(position_command[15:0]))    :
        (s == DMDS_SEL_PCMD_HI)  ? 17'(signed'(position_command[31:16]))   :
        (s == DMDS_SEL_FBPOS_LO) ? 17'(signed'(feedback_position[15:0]))   :
        (s == DMDS_SEL_FBPOS_HI) ? 17'(signed'(feedback_position[31:16]))  :
        is_in  ? {1'b0, control_input_words[in_idx[1:0]]}                  :
        is_out ? {1'b0, control_output_words[out_idx[1:0]]}                :
        17'h0;
      assign gain_w[c] = (gain_r[c] == 16'h0000) ? DMDS_GAIN_UNITY
                                                 : 17'(signed'(gain_r[c]));
      // multiply then drop eight fraction bits
      assign scaled_w[c] = 34'($signed(data_w[c]) * $signed(gain_w[c])) >>> DMDS_GAIN_SHIFT;
      // offset binary around mid-scale, clamp to code range
      assign lin_w[c] =
        ($signed(scaled_w[c]) > $signed(34'sh7F))  ? DMDS_CODE_FULL :
        ($signed(scaled_w[c]) < -$signed(34'sh80)) ? DMDS_CODE_ZERO :
        (scaled_w[c][7:0] ^ DMDS_CODE_MID);
      assign code_nxt[c] = (s == DMDS_SEL_METER) ? ((c == 0) ? spd_code_r : load_code_r)
                                                 : lin_w[c];
    end
  endgenerate

  // Converter codes held in flops so the converter sees clean edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) code_r <= {2{DMDS_CODE_ZERO}};
    else       code_r <= code_nxt;
  end

  assign dac_code_ch1 = code_r[0];
  assign dac_code_ch2 = code_r[1];

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0;
    status_w[7:0] = code_r[0];
    status_w[DMDS_ST_CODE2_LSB +: 8] = code_r[1];
    status_w[DMDS_ST_HIGH_BIT]   = high_coil_active;
    status_w[DMDS_ST_LOW_BIT]    = low_coil_active;
    status_w[DMDS_ST_SINGLE_BIT] = single_coil_special;
  end

  // Unmapped addresses read as zero
  wire [31:0] rd_mux =
    (reg_addr == DMDS_ADDR_SPEED_FS) ? {16'h0, speed_fs_r} :
    (reg_addr == DMDS_ADDR_LOAD_V)   ? {16'h0, load_v_r}   :
    (reg_addr == DMDS_ADDR_CH1_SEL)  ? {16'h0, sel_r[0]}   :
    (reg_addr == DMDS_ADDR_CH2_SEL)  ? {16'h0, sel_r[1]}   :
    (reg_addr == DMDS_ADDR_CH1_GAIN) ? {16'h0, gain_r[0]}  :
    (reg_addr == DMDS_ADDR_CH2_GAIN) ? {16'h0, gain_r[1]}  :
    (reg_addr == DMDS_ADDR_SFW2)     ? {16'h0, sfw2_r}     :
    (reg_addr == DMDS_ADDR_STATUS)   ? status_w            :
    32'h0;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata_r <= 32'h0;
    else       rdata_r <= reg_rd ? rd_mux : 32'h0;
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ch1_meter_route: assert property (
    (sel_r[0] == DMDS_SEL_METER) |=> (dac_code_ch1 == $past(spd_code_r)))
    else $error("channel 1 not carrying speed meter");
  a_ch2_meter_route: assert property (
    (sel_r[1] == DMDS_SEL_METER) |=> (dac_code_ch2 == $past(load_code_r)))
    else $error("channel 2 not carrying load meter");
  a_gain_zero_unity: assert property (
    (gain_r[0] == 16'h0000) |-> (scaled_w[0] == 34'($signed(data_w[0]))))
    else $error("zero gain not unity");
  a_signed_clamp_low: assert property (
    (sel_r[1] != DMDS_SEL_METER && $signed(scaled_w[1]) < -$signed(34'sh80))
      |=> (dac_code_ch2 == DMDS_CODE_ZERO))
    else $error("negative overflow not clamped");
  a_cur_cmd_route: assert property (
    (sel_r[0] == DMDS_SEL_CUR_CMD) |-> ($signed(data_w[0]) == $signed(current_command)))
    else $error("current command not selected");
  a_droop_high_half: assert property (
    (sel_r[1] == DMDS_SEL_DROOP_HI)
      |-> ($signed(data_w[1]) == $signed(position_droop[31:16])))
    else $error("droop high half not selected");
  a_ctl_word_ext: assert property (
    (sel_r[0] == DMDS_SEL_CTL_IN1) |-> (data_w[0] == {1'b0, control_input_words[0]}))
    else $error("control word not zero-extended");
  a_load_full_scale: assert property (
    (div_last && meter_r && num_lat_r == den_r * DMDS_METER_SPAN)
      |=> (load_code_r == DMDS_CODE_FULL))
    else $error("load at full scale not full code");
  a_mid_scale_zero: assert property (
    (sel_r[1] != DMDS_SEL_METER && data_w[1] == 17'h0) |=> (dac_code_ch2 == DMDS_CODE_MID))
    else $error("zero data not at mid-scale");
  a_signed_clamp_high: assert property (
    (sel_r[0] != DMDS_SEL_METER && $signed(scaled_w[0]) > $signed(34'sh7F))
      |=> (dac_code_ch1 == DMDS_CODE_FULL))
    else $error("positive overflow not clamped");
  a_speed_default_max: assert property (
    (speed_fs_r == 16'h0000) |-> (eff_fs == maximum_motor_speed))
    else $error("zero full scale not using maximum speed");
  a_load_default_ten: assert property (
    (load_v_r == 16'h0000) |-> (eff_lv == DMDS_LOAD_V_FULL))
    else $error("zero load voltage not 10 V");
  a_speed_full_scale: assert property (
    (div_last && !meter_r && num_lat_r == den_r * DMDS_METER_SPAN)
      |=> (spd_code_r == DMDS_CODE_FULL))
    else $error("speed at full scale not full code");
  a_low_coil_both: assert property (
    low_coil_active |-> (high_coil_active && !single_coil_special))
    else $error("low coil set without changeover");
  a_divider_bounded: assert property (
    (st_r == DMDS_ST_DIV && bit_r == DMDS_DIV_TOP_BIT) |-> ##7 div_last)
    else $error("meter divide not done in eight steps");

  c_ch1_meter:   cover property (sel_r[0] == DMDS_SEL_METER && meter_upd && !meter_r);
  c_ch2_signed:  cover property (sel_r[1] == DMDS_SEL_CUR_FB && data_w[1] != 17'h0);
  c_ctl_word:    cover property (sel_r[0] == DMDS_SEL_CTL_OUT1 && data_w[0] != 17'h0);
  c_speed_done:  cover property (div_last && !meter_r);
  c_low_coil:    cover property (low_coil_active);
endmodule // dmds_top

`default_nettype wire

// *** verification/dmds_dac_model.sv ***
// Behavioural model of the two-channel 8-bit monitor output converter.
// Assumes codes settle before each rising clk edge; levels are in millivolts.
`default_nettype none

module dmds_dac_model (
  input  wire logic [7:0] code_a,
  input  wire logic [7:0] code_b,
  input  wire logic       clk,
  output var  int         mv_a,
  output var  int         mv_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Conversion, code 255 is 10 V and code 0 is 0 V
  // ----------------------------------------------------------------------
  // An undriven code shows as a bad level, so it cannot pass for 0 V
  always @(posedge clk) begin
    mv_a <= $isunknown(code_a) ? -1 : int'(code_a) * 10000 / 255;
    mv_b <= $isunknown(code_b) ? -1 : int'(code_b) * 10000 / 255;
  end
endmodule // dmds_dac_model

`default_nettype wire

// *** verification/dmds_top_tb_top.sv ***
// Self-checking bench for the monitor output selector and scaler.
// Assumes dmds_pkg, dmds_top and dmds_dac_model are compiled before this file.
`default_nettype none

module dmds_top_tb_top;
  import dmds_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------------
  logic             clk;
  logic             nrst;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_rdata;
  logic [15:0]      max_spd, cur_cmd, cur_fb, spd_fb, load;
  logic [31:0]      droop, incr, pcmd, fbpos, rv;
  logic [3:0][15:0] ctl_in, ctl_out;
  logic [7:0]       code1, code2;
  logic             hi_coil, lo_coil, single;
  int               mv1, mv2;
  int               err_total = 0;
  int               n_tests   = 0;
  int               cycles    = 0;
  // Gain, feedback, expected code on the signed curve
  localparam logic [15:0] G_TAB[6] = '{16'h0006, 16'h0006, 16'h0100, 16'h0100, 16'hFF00, 16'h0000};
  localparam logic [15:0] F_TAB[6] = '{16'h1333, 16'hECCD, 16'h1333, 16'hECCD, 16'h0064, 16'hFFEC};
  localparam logic [7:0]  E_TAB [6] = '{8'hF3, 8'h0C, 8'hFF, 8'h00, 8'h1C, 8'h6C};
  // Meter rows: full-scale speed, max speed, speed, load volts, load, codes
  localparam logic [15:0] FS_T [4] = '{16'h03E8, 16'h03E8, 16'h0000, 16'h0000};
  localparam logic [15:0] MX_T [4] = '{16'h0000, 16'h0000, 16'h07D0, 16'h07D0};
  localparam logic [15:0] SP_T [4] = '{16'h01F4, 16'hFE0C, 16'h03E8, 16'h07D0};
  localparam logic [15:0] LV_T [4] = '{16'h0000, 16'h0005, 16'h0000, 16'h000A};
  localparam logic [15:0] LD_T [4] = '{16'h0999, 16'h1333, 16'h1333, 16'h0000};
  localparam logic [7:0]  S_EX [4] = '{8'h7F, 8'h7F, 8'h7F, 8'hFF};
  localparam logic [7:0]  L_EX [4] = '{8'h7F, 8'h7F, 8'hFF, 8'h00};
  localparam logic [2:0]  C_EX [4] = '{3'b000, 3'b101, 3'b000, 3'b011};

  // ----------------------------------------------------------------------
  // Design, converter model and clock
  // ----------------------------------------------------------------------
  dmds_top i_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .maximum_motor_speed(max_spd),
    .current_command(cur_cmd), .current_feedback(cur_fb), .speed_feedback(spd_fb),
    .motor_load(load), .position_droop(droop), .position_increment(incr),
    .position_command(pcmd), .feedback_position(fbpos), .control_input_words(ctl_in),
    .control_output_words(ctl_out), .dac_code_ch1(code1), .dac_code_ch2(code2),
    .high_coil_active(hi_coil), .low_coil_active(lo_coil), .single_coil_special(single));

  dmds_dac_model i_dac (.clk(clk), .code_a(code1), .code_b(code2), .mv_a(mv1), .mv_b(mv2));

  // 125 MHz clock
  always #4 clk = ~clk;

  // Hang guard, well above the roughly 800 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    clk       = 1'b0;
    nrst      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    max_spd   = 16'h0000;
    cur_cmd   = 16'h0002;
    cur_fb    = 16'h0003;
    spd_fb    = 16'h0004;
    load      = 16'h0000;
    droop     = 32'h0007_0006;
    incr      = 32'h0009_0008;
    pcmd      = 32'h000B_000A;
    fbpos     = 32'h000D_000C;
    for (int i = 0; i < 4; i++) begin
      ctl_in[i]  = 16'h0050 + 16'(i);
      ctl_out[i] = 16'h0054 + 16'(i);
    end
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, read-back width, unmapped places
    for (int a = 0; a < 7; a++) begin
      rd(8'(a * 4), rv);
      chk("reset value", rv, 32'h0000_0000);
    end
    wr(DMDS_ADDR_CH1_GAIN, 32'hFFFF_8001);
    rd(DMDS_ADDR_CH1_GAIN, rv);
    chk("gain readback", rv, 32'h0000_8001);
    wr(DMDS_ADDR_CH1_GAIN, 32'h0000_0000);
    wr(8'h24, 32'h0000_FFFF);
    rd(8'h24, rv);
    chk("unmapped read", rv, 32'h0000_0000);
    $display("test registers done");
    // Data numbers 1 to 90 at gain 0; each source carries its own number
    for (int n = 1; n < 91; n++) begin
      wr(DMDS_ADDR_CH1_SEL, 32'(n));
      wr(DMDS_ADDR_CH2_SEL, 32'(n));
      settle(2);
      rv = ((n >= 2 && n <= 13 && n != 5) || (n >= 80 && n <= 87)) ? 32'(128 + n) : 32'h80;
      chk("ch1 data number", code1, rv[7:0]);
      chk("ch2 data number", code2, rv[7:0]);
    end
    wr(DMDS_ADDR_CH1_SEL, 32'h0000_FFFF);
    settle(2);
    chk("negative data number", code1, 8'h80);
    // Top bit of a control word must not turn into a sign
    wr(DMDS_ADDR_CH1_SEL, 32'h0000_0057);
    ctl_out[3] <= 16'h8000;
    settle(2);
    chk("control word top bit", code1, 8'hFF);
    $display("test data numbers done");
    // Signed curve with gain, clamping and negative gain on channel 2
    wr(DMDS_ADDR_CH2_SEL, 32'(DMDS_SEL_CUR_FB));
    for (int i = 0; i < 6; i++) begin
      wr(DMDS_ADDR_CH2_GAIN, 32'(G_TAB[i]));
      cur_fb <= F_TAB[i];
      settle(3);
      chk("signed code", code2, E_TAB[i]);
      if (i == 0) chk("converter mv", 32'(mv2), 32'h0000_2539);
    end
    wr(DMDS_ADDR_CH1_SEL, 32'(DMDS_SEL_SPEED_FB));
    wr(DMDS_ADDR_CH1_GAIN, 32'h0000_0010);
    spd_fb <= 16'h07D0;
    settle(2);
    chk("speed feedback code", code1, 8'hFD);
    chk("converter mv ch1", 32'(mv1), 32'h0000_26C1);
    $display("test signed curve done");
    // Meters on select 0, ch1 gain left at 16 to show it is not applied
    wr(DMDS_ADDR_CH1_SEL, 32'h0);
    wr(DMDS_ADDR_CH2_SEL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(DMDS_ADDR_SPEED_FS, 32'(FS_T[i]));
      wr(DMDS_ADDR_LOAD_V, 32'(LV_T[i]));
      max_spd <= MX_T[i];
      spd_fb  <= SP_T[i];
      load    <= LD_T[i];
      settle(40);
      chk("speed meter", code1, S_EX[i]);
      chk("load meter", code2, L_EX[i]);
    end
    $display("test meters done");
    // Motor constant set decode from special function word 2
    // special function word 2 written with 0, 1, 4 and 5 in turn
    for (int i = 0; i < 4; i++) begin
      wr(DMDS_ADDR_SFW2, 32'(i + (i / 2) * 2));
      rd(DMDS_ADDR_STATUS, rv);
      chk("coil outputs", {29'h0, single, lo_coil, hi_coil}, 32'(C_EX[i]));
      chk("coil status", 32'(rv[18:16]), 32'(C_EX[i]));
    end
    $display("test coil sets done");
    // Mid-run reset clears codes, settings and the coil decode
    @(posedge clk);
    nrst <= 1'b0;
    settle(1);
    chk("codes in reset", {code2, code1}, 16'h0000);
    chk("coil in reset", {29'h0, single, lo_coil, hi_coil}, 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    rd(DMDS_ADDR_SFW2, rv);
    chk("special word after reset", rv, 32'h0000_0000);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule // dmds_top_tb_top

`default_nettype wire
